//--- hdl/flw_axil.sv
/*
 flw_axil: axi4-lite slave front end; turns bus transfers into one-cycle
 register write strobes and a combinational read lookup.
 assumes: the parent decodes wr_addr / rd_addr the same cycle.
*/
`timescale 1ns/1ps
module flw_axil #(
   parameter int unsigned ADDR_W = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [31:0]       s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   input  wire logic [ADDR_W-1:0] s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [31:0]            s_rdata,
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready,
   output logic                   wr_en,
   output logic [ADDR_W-1:0]      wr_addr,
   output logic [31:0]            wr_data,
   output logic [3:0]             wr_strb,
   input  wire logic              wr_ok,
   output logic [ADDR_W-1:0]      rd_addr,
   input  wire logic [31:0]       rd_data,
   input  wire logic              rd_ok
);
   logic              aw_held_r;
   logic              w_held_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;

   assign wr_en   = aw_held_r && w_held_r && !s_bvalid;
   assign wr_addr = awaddr_r;
   assign wr_data = wdata_r;
   assign wr_strb = wstrb_r;
   assign rd_addr = s_araddr;

   // write address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         s_bvalid  <= 1'b0;
         s_bresp   <= flw_pkg::RESP_OKAY;
      end else begin
         if (wr_en) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            s_bvalid  <= 1'b1;
            s_bresp   <= wr_ok ? flw_pkg::RESP_OKAY : flw_pkg::RESP_SLVERR;
         end else begin
            if (s_awvalid && s_awready) begin
               aw_held_r <= 1'b1;
               awaddr_r  <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
               w_held_r <= 1'b1;
               wdata_r  <= s_wdata;
               wstrb_r  <= s_wstrb;
            end
         end
         if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
         s_awready <= !aw_held_r && !(s_awvalid && s_awready) && !s_bvalid;
         s_wready  <= !w_held_r && !(s_wvalid && s_wready) && !s_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0000_0000;
         s_rresp   <= flw_pkg::RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b1;
         s_rdata   <= rd_ok ? rd_data : 32'h0000_0000;
         s_rresp   <= rd_ok ? flw_pkg::RESP_OKAY : flw_pkg::RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid  <= 1'b0;
      end else begin
         s_arready <= !s_rvalid;
      end
   end
endmodule

//--- hdl/flw_pkg.sv
/*
 flw_pkg: constants shared by the first-level walk block and its bus slave.
 assumes: 32-bit descriptors, byte-addressed register window of 8 address bits.
*/
package flw_pkg;
   // first-level table geometry
   localparam int unsigned TABLE_ENTRIES = 4096;
   localparam int unsigned IDX_W         = 12;
   localparam int unsigned SECT_LSB      = 20;
   localparam int unsigned TBASE_LSB     = 14;
   localparam int unsigned COARSE_LSB    = 10;
   localparam int unsigned FINE_LSB      = 12;
   localparam int unsigned AP_LSB        = 10;
   localparam int unsigned DOM_LSB       = 5;
   localparam int unsigned CB_LSB        = 2;
   localparam int unsigned COARSE_ENTRIES = 256;
   localparam int unsigned FINE_ENTRIES   = 1024;

   // descriptor type field, bits [1:0]
   typedef enum logic [1:0] {
      FLW_DESC_FAULT   = 2'h0,
      FLW_DESC_COARSE  = 2'h1,
      FLW_DESC_SECTION = 2'h2,
      FLW_DESC_FINE    = 2'h3
   } flw_desc_t;

   // memory class from c,b bits
   typedef enum logic [1:0] {
      FLW_MEM_UNCACHED_UNBUF = 2'h0,
      FLW_MEM_UNCACHED_BUF   = 2'h1,
      FLW_MEM_WRITE_THROUGH  = 2'h2,
      FLW_MEM_WRITE_BACK     = 2'h3
   } flw_mem_t;

   // fault status code for a section translation fault
   localparam logic [3:0] FAULT_SECTION = 4'h5;

   // register byte offsets
   localparam logic [7:0] REG_TBASE     = 8'h00;
   localparam logic [7:0] REG_CTRL      = 8'h04;
   localparam logic [7:0] REG_STATUS    = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT  = 8'h0C;
   localparam logic [7:0] REG_IRQ_EN    = 8'h10;
   localparam logic [7:0] REG_IRQ_CLR   = 8'h14;
   localparam logic [7:0] REG_LAST_DESC = 8'h18;

   // reset values
   localparam logic [31:0] TBASE_RST  = 32'h0000_0000;
   localparam logic        ENABLE_RST = 1'b0;
   localparam logic [2:0]  IRQ_EN_RST = 3'h0;

   // interrupt event bits
   localparam int unsigned IRQ_N       = 3;
   localparam int unsigned IRQ_SECTION = 0;
   localparam int unsigned IRQ_FAULT   = 1;
   localparam int unsigned IRQ_L2      = 2;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- hdl/flw_walk.sv
/*
 flw_walk: first-level stage of the translation table walk, with an axi4-lite
 register window for the table base, enable, status and interrupts.
 assumes: the memory port answers on the same clock with one mem_rvalid pulse
 per request; second-level fetch and permission checks sit downstream.
*/
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
// Behaviour
// RULE1: table has 4096 word entries, 1MB each
// RULE2: fetch address is base[31:14] over va[31:20]
// RULE3: each fetch reads one aligned word descriptor
// RULE4: type 00 raises a section translation fault
// RULE5: type 01 coarse, 10 section, 11 fine
// RULE6: section bits [31:20] give physical upper bits
// RULE7: section bits [11:10] give access permission field
// RULE8: bits [8:5] give domain for every kind
// RULE9: section c,b bits classify memory type
// RULE10: coarse bits [31:10] give 256-entry table base
// RULE11: fine bits [31:12] give 1024-entry table base
// RULE12: page tables start second fetch, sections end
// RULE13: software sets section bit 4 to one
// RULE14: software marks coarse descriptors with 01
// RULE15: walk starts only on translation buffer miss
// RULE16: software aligns table base to 16KB
// RULE17: section address is desc[31:20] plus va[19:0]
// RULE18: fault reports type and domain, loads nothing
`timescale 1ns/1ps
module flw_walk #(
   parameter int unsigned ADDR_W = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [31:0]       s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   input  wire logic [ADDR_W-1:0] s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [31:0]            s_rdata,
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready,
   input  wire logic              req_valid,
   input  wire logic [31:0]       modified_virtual_address,
   input  wire logic              translation_buffer_hit,
   output logic                   req_ready,
   output logic                   mem_req,
   output logic [31:0]            mem_addr,
   input  wire logic              mem_rvalid,
   input  wire logic [31:0]       mem_rdata,
   output logic                   walk_done,
   output logic [1:0]             walk_kind,
   output logic                   tb_load,
   output logic [31:0]            sect_phys_addr,
   output logic [1:0]             access_permission_field,
   output logic [3:0]             domain,
   output logic [1:0]             mem_class,
   output logic                   l2_start,
   output logic [31:0]            l2_table_base,
   output logic                   l2_fine,
   output logic                   fault_valid,
   output logic [3:0]             fault_status,
   output logic [3:0]             fault_domain,
   output logic                   irq
);
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FETCH = 3'b010,
      ST_END   = 3'b100
   } flw_state_t;

   localparam int unsigned IRQ_W = flw_pkg::IRQ_N;

   flw_state_t        state_r;
   logic [31:0]       tbase_r;
   logic              enable_r;
   logic [31:0]       mva_r;
   logic [31:0]       last_desc_r;
   logic [IRQ_W-1:0]  irq_stat_r;
   logic [IRQ_W-1:0]  irq_en_r;
   logic [IRQ_W-1:0]  irq_evt;
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic              wr_ok;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0]       rd_data;
   logic              rd_ok;
   logic              start;
   logic              desc_in;
   logic [1:0]        desc_type;
   flw_axil #(
      .ADDR_W (ADDR_W)
   ) u_axil (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .wr_en     (wr_en),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .wr_strb   (wr_strb),
      .wr_ok     (wr_ok),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data),
      .rd_ok     (rd_ok)
   );

   assign start     = (state_r == ST_IDLE) && enable_r && req_valid && !translation_buffer_hit; // RULE15
   assign desc_in   = (state_r == ST_FETCH) && mem_rvalid;
   assign desc_type = mem_rdata[1:0];

   // address decode; status registers take writes silently
   always_comb begin
      wr_ok = 1'b1;
      case (wr_addr)
         flw_pkg::REG_TBASE, flw_pkg::REG_CTRL, flw_pkg::REG_STATUS, flw_pkg::REG_IRQ_STAT,
         flw_pkg::REG_IRQ_EN, flw_pkg::REG_IRQ_CLR, flw_pkg::REG_LAST_DESC: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_comb begin
      rd_ok   = 1'b1;
      rd_data = 32'h0000_0000;
      case (rd_addr)
         flw_pkg::REG_TBASE:     rd_data = {tbase_r[31:flw_pkg::TBASE_LSB], 14'h0000};
         flw_pkg::REG_CTRL:      rd_data = {31'h0000_0000, enable_r};
         flw_pkg::REG_STATUS:    rd_data = {25'h000_0000, last_desc_r[8:5], last_desc_r[1:0],
                                            state_r != ST_IDLE};
         flw_pkg::REG_IRQ_STAT:  rd_data = {29'h0000_0000, irq_stat_r};
         flw_pkg::REG_IRQ_EN:    rd_data = {29'h0000_0000, irq_en_r};
         flw_pkg::REG_IRQ_CLR:   rd_data = 32'h0000_0000;
         flw_pkg::REG_LAST_DESC: rd_data = last_desc_r;
         default: rd_ok = 1'b0;
      endcase
   end

   // software registers, byte lanes honoured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tbase_r  <= flw_pkg::TBASE_RST;
         enable_r <= flw_pkg::ENABLE_RST;
         irq_en_r <= flw_pkg::IRQ_EN_RST;
      end else if (wr_en) begin
         if (wr_addr == flw_pkg::REG_TBASE) begin
            for (int b = 0; b < 4; b++) begin
               if (wr_strb[b]) begin
                  tbase_r[b*8 +: 8] <= wr_data[b*8 +: 8];
               end
            end
         end
         if (wr_addr == flw_pkg::REG_CTRL && wr_strb[0]) begin
            enable_r <= wr_data[0];
         end
         if (wr_addr == flw_pkg::REG_IRQ_EN && wr_strb[0]) begin
            irq_en_r <= wr_data[IRQ_W-1:0];
         end
      end
   end

   // sticky events; a new event beats a same-cycle clear
   assign irq_evt[flw_pkg::IRQ_SECTION] = desc_in && desc_type == flw_pkg::FLW_DESC_SECTION;
   assign irq_evt[flw_pkg::IRQ_FAULT]   = desc_in && desc_type == flw_pkg::FLW_DESC_FAULT;
   assign irq_evt[flw_pkg::IRQ_L2]      = desc_in && desc_type[0];

   generate
      for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               irq_stat_r[i] <= 1'b0;
            end else if (irq_evt[i]) begin
               irq_stat_r[i] <= 1'b1;
            end else if (wr_en && wr_addr == flw_pkg::REG_IRQ_CLR && wr_strb[0] && wr_data[i]) begin
               irq_stat_r[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_r & irq_en_r);
      end
   end

   // walk sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r   <= ST_IDLE;
         req_ready <= 1'b0;
         mem_req   <= 1'b0;
         mem_addr  <= 32'h0000_0000;
         mva_r     <= 32'h0000_0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               req_ready <= 1'b1;
               if (start) begin
                  state_r   <= ST_FETCH;
                  req_ready <= 1'b0;
                  mva_r     <= modified_virtual_address;
                  mem_req   <= 1'b1;
                  // word index: 12 table bits select one of 4096 entries
                  mem_addr  <= {tbase_r[31:flw_pkg::TBASE_LSB],
                                modified_virtual_address[31:flw_pkg::SECT_LSB], 2'h0}; // RULE1 RULE2 RULE3
               end
            end
            ST_FETCH: begin
               if (mem_rvalid) begin
                  mem_req <= 1'b0; // RULE3
                  state_r <= ST_END;
               end
            end
            ST_END: begin
               state_r   <= ST_IDLE;
               req_ready <= 1'b1;
            end
            default: begin
               state_r   <= ST_IDLE;
               mem_req   <= 1'b0;
               req_ready <= 1'b0;
            end
         endcase
      end
   end

   // one-cycle result pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         walk_done   <= 1'b0;
         tb_load     <= 1'b0;
         l2_start    <= 1'b0;
         fault_valid <= 1'b0;
      end else begin
         walk_done   <= desc_in;
         tb_load     <= desc_in && desc_type == flw_pkg::FLW_DESC_SECTION; // RULE12 RULE18
         l2_start    <= desc_in && desc_type[0];                           // RULE12
         fault_valid <= desc_in && desc_type == flw_pkg::FLW_DESC_FAULT;   // RULE4
      end
   end

   // decoded fields, held until the next descriptor
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_desc_r             <= 32'h0000_0000;
         walk_kind               <= flw_pkg::FLW_DESC_FAULT;
         sect_phys_addr          <= 32'h0000_0000;
         access_permission_field <= 2'h0;
         domain                  <= 4'h0;
         mem_class               <= flw_pkg::FLW_MEM_UNCACHED_UNBUF;
         l2_table_base           <= 32'h0000_0000;
         l2_fine                 <= 1'b0;
         fault_status            <= 4'h0;
         fault_domain            <= 4'h0;
      end else if (desc_in) begin
         last_desc_r <= mem_rdata;
         walk_kind   <= desc_type; // RULE5
         domain      <= mem_rdata[flw_pkg::DOM_LSB +: 4]; // RULE8
         case (desc_type)
            flw_pkg::FLW_DESC_SECTION: begin
               sect_phys_addr          <= {mem_rdata[31:flw_pkg::SECT_LSB], mva_r[19:0]}; // RULE6 RULE17
               access_permission_field <= mem_rdata[flw_pkg::AP_LSB +: 2];               // RULE7
               mem_class               <= mem_rdata[flw_pkg::CB_LSB +: 2];               // RULE9
            end
            flw_pkg::FLW_DESC_COARSE: begin
               l2_table_base <= {mem_rdata[31:flw_pkg::COARSE_LSB], 10'h000}; // RULE10
               l2_fine       <= 1'b0;
            end
            flw_pkg::FLW_DESC_FINE: begin
               l2_table_base <= {mem_rdata[31:flw_pkg::FINE_LSB], 12'h000}; // RULE11
               l2_fine       <= 1'b1;
            end
            default: begin
               fault_status <= flw_pkg::FAULT_SECTION;        // RULE18
               fault_domain <= mem_rdata[flw_pkg::DOM_LSB +: 4]; // RULE18
            end
         endcase
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_desc(logic [1:0] k);
      desc_in && desc_type == k;
   endsequence

   sequence s_start;
      !mem_req ##1 mem_req;
   endsequence

   chk_start_miss: assert property (s_start |-> $past(req_valid && !translation_buffer_hit && enable_r)) // RULE15
      else $error("walk started without a translation buffer miss");
   chk_fetch_addr: assert property (s_start |-> mem_addr[31:14] == $past(tbase_r[31:14])
                                              && mem_addr[13:2] == mva_r[31:20]) // RULE2
      else $error("first-level fetch address wrong");
   chk_fetch_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0 ##1 (mem_req || walk_done)) // RULE3
      else $error("fetch unaligned or dropped");
   chk_fault_report: assert property (s_desc(2'h0) |=> fault_valid && !tb_load && !l2_start
                                      && fault_status == flw_pkg::FAULT_SECTION
                                      && fault_domain == $past(mem_rdata[8:5])) // RULE4
      else $error("section translation fault not reported");
   chk_kind_decode: assert property (desc_in |=> walk_done && walk_kind == $past(mem_rdata[1:0])
                                     && l2_start == walk_kind[0]) // RULE5
      else $error("descriptor kind decoded wrongly");
   chk_section_addr: assert property (s_desc(2'h2) |=> tb_load
                                      && sect_phys_addr == {$past(mem_rdata[31:20]), mva_r[19:0]}) // RULE6
      else $error("section physical address wrong");
   chk_section_perm: assert property (s_desc(2'h2) |=> access_permission_field == $past(mem_rdata[11:10])
                                      && mem_class == $past(mem_rdata[3:2])) // RULE7
      else $error("section permission or class wrong");
   chk_domain_field: assert property (desc_in |=> domain == $past(mem_rdata[8:5])) // RULE8
      else $error("domain field wrong");
   chk_coarse_base: assert property (s_desc(2'h1) |=> l2_start && !l2_fine
                                     && l2_table_base == {$past(mem_rdata[31:10]), 10'h000}) // RULE10
      else $error("coarse table base wrong");
   chk_fine_base: assert property (s_desc(2'h3) |=> l2_start && l2_fine
                                   && l2_table_base == {$past(mem_rdata[31:12]), 12'h000}) // RULE11
      else $error("fine table base wrong");
   chk_walk_end: assert property (s_desc(2'h2) |=> !l2_start ##1 !mem_req) // RULE12
      else $error("section walk did not end after one fetch");
endmodule

//--- test/first_level_table_walk_tb.sv
/*
 first_level_table_walk_tb: walks of every descriptor type, refusals, registers.
 assumes: flw_walk with its default address width, flw_mem_model as memory.
*/
`timescale 1ns/1ps
module first_level_table_walk_tb;
   logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, req_ready, mem_req, mem_rvalid;
   logic        req_valid, translation_buffer_hit, walk_done, tb_load, l2_start, l2_fine, fault_valid, irq;
   logic [7:0]  s_awaddr, s_araddr;
   logic [3:0]  s_wstrb, domain, fault_status, fault_domain;
   logic [1:0]  s_bresp, s_rresp, walk_kind, access_permission_field, mem_class, lat, rr;
   logic [31:0] s_wdata, s_rdata, modified_virtual_address, mem_addr, mem_rdata, desc;
   logic [31:0] sect_phys_addr, l2_table_base, seed, tbase, rd, va, d;
   int          n_errors, n_compared, i;

   flw_walk u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .req_valid(req_valid),
      .modified_virtual_address(modified_virtual_address), .translation_buffer_hit(translation_buffer_hit),
      .req_ready(req_ready), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
      .walk_done(walk_done), .walk_kind(walk_kind), .tb_load(tb_load), .sect_phys_addr(sect_phys_addr),
      .access_permission_field(access_permission_field), .domain(domain), .mem_class(mem_class),
      .l2_start(l2_start), .l2_table_base(l2_table_base), .l2_fine(l2_fine), .fault_valid(fault_valid),
      .fault_status(fault_status), .fault_domain(fault_domain), .irq(irq)
   );
   flw_mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req), .desc(desc), .lat(lat),
      .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] fetch_addr(input logic [31:0] b, input logic [31:0] v);
      return {b[31:14], v[31:20], 2'h0};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic tmo();
      n_errors++;
      $display("ERROR wait expected answer seen none");
      results();
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = flw_pkg::RESP_OKAY);
      int k;
      @(posedge aclk);
      s_awaddr  <= a;
      s_wdata   <= v;
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
         if (s_bvalid) break;
      end
      s_bready <= 1'b0;
      if (k == 50) tmo();
      chk("bresp", 32'(er), 32'(s_bresp));
   endtask

   task automatic axi_rd(input logic [7:0] a);
      int k;
      @(posedge aclk);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'b0;
         if (s_rvalid) break;
      end
      rd = s_rdata;
      rr = s_rresp;
      s_rready <= 1'b0;
      if (k == 50) tmo();
   endtask

   task automatic noreq(input logic h);
      @(posedge aclk);
      translation_buffer_hit <= h;
      req_valid <= 1'b1;
      repeat (4) begin
         @(posedge aclk);
         #1 chk("no_fetch", 32'h0, 32'(mem_req));
         chk("idle_ready", 32'h1, 32'(req_ready));
      end
      req_valid <= 1'b0;
      translation_buffer_hit <= 1'b0;
   endtask

   task automatic walk();
      int k;
      @(posedge aclk);
      modified_virtual_address <= va;
      desc      <= d;
      lat       <= 2'(xs());
      req_valid <= 1'b1;
      @(posedge aclk);
      req_valid <= 1'b0;
      #1 chk("mem_req", 32'h1, 32'(mem_req));
      chk("req_ready", 32'h0, 32'(req_ready));
      chk("mem_addr", fetch_addr(tbase, va), mem_addr);
      for (k = 0; k < 20; k++) begin
         @(posedge aclk);
         #1;
         if (walk_done === 1'b1) break;
      end
      if (k == 20) tmo();
      chk("kind", 32'(d[1:0]), 32'(walk_kind));
      chk("fault", 32'(d[1:0] == 2'h0), 32'(fault_valid));
      chk("load", 32'(d[1:0] == 2'h2), 32'(tb_load));
      chk("l2", 32'(d[0]), 32'(l2_start));
      if (d[1:0] == 2'h0) begin
         chk("fstat", 32'(flw_pkg::FAULT_SECTION), 32'(fault_status));
         chk("fdom", 32'(d[8:5]), 32'(fault_domain));
      end else chk("dom", 32'(d[8:5]), 32'(domain));
      if (d[1:0] == 2'h2) begin
         chk("pa", {d[31:20], va[19:0]}, sect_phys_addr);
         chk("ap", 32'(d[11:10]), 32'(access_permission_field));
         chk("cls", 32'(d[3:2]), 32'(mem_class));
      end
      if (d[0]) chk("l2fine", 32'(d[1]), 32'(l2_fine));
      if (d[0]) chk("l2base", d[1] ? {d[31:12], 12'h0} : {d[31:10], 10'h0}, l2_table_base);
   endtask

   initial begin
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, req_valid, translation_buffer_hit} = '0;
      {s_awaddr, s_araddr, s_wdata, modified_virtual_address, desc, lat} = '0;
      s_wstrb = 4'hF;
      seed = 32'h0001_7561;
      n_errors = 0;
      n_compared = 0;
      aresetn = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      noreq(1'b0);
      tbase = xs() & 32'hFFFF_C000;
      axi_wr(flw_pkg::REG_TBASE, tbase);
      axi_rd(flw_pkg::REG_TBASE);
      chk("tbase", tbase, rd);
      axi_wr(flw_pkg::REG_IRQ_EN, 32'h7);
      axi_wr(flw_pkg::REG_CTRL, 32'h1);
      noreq(1'b1);
      $display("refusal test done");
      for (i = 0; i < 40; i++) begin
         va = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_FFFF : xs();
         d = xs() | 32'h10;
         if (i < 4) d[1:0] = 2'(i);
         walk();
      end
      axi_rd(flw_pkg::REG_LAST_DESC);
      chk("last_desc", d, rd);
      axi_rd(flw_pkg::REG_STATUS);
      chk("status", {25'h0, d[8:5], d[1:0], 1'b0}, rd);
      $display("walk test done");
      axi_rd(flw_pkg::REG_IRQ_STAT);
      chk("irq_stat", 32'h7, rd);
      chk("irq_on", 32'h1, 32'(irq));
      axi_wr(flw_pkg::REG_IRQ_EN, 32'h0);
      repeat (2) @(posedge aclk);
      #1 chk("irq_masked", 32'h0, 32'(irq));
      axi_wr(flw_pkg::REG_IRQ_CLR, 32'h7);
      axi_rd(flw_pkg::REG_IRQ_STAT);
      chk("irq_clear", 32'h0, rd);
      axi_wr(8'h40, 32'h1, flw_pkg::RESP_SLVERR);
      axi_rd(8'h40);
      chk("unmapped_resp", 32'(flw_pkg::RESP_SLVERR), 32'(rr));
      chk("unmapped_data", 32'h0, rd);
      $display("register test done");
      results();
   end
endmodule

//--- test/flw_mem_model.sv
/*
 flw_mem_model: table memory answering the walk's descriptor fetches.
 assumes: the bench sets the word and the delay before each fetch.
*/
`timescale 1ns/1ps
module flw_mem_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        mem_req,
   input  wire logic [31:0] desc,
   input  wire logic [1:0]  lat,
   output logic             mem_rvalid,
   output logic [31:0]      mem_rdata
);
   logic [1:0] cnt_r;
   initial mem_rvalid = 1'b0;
   initial mem_rdata = 32'h0;
   initial cnt_r = 2'h0;
   always @(posedge aclk) begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata; // inverted every cycle outside a reply, so the last word comes back every second cycle
      if (!aresetn) begin
         cnt_r <= 2'h0;
      end else if (mem_req && !mem_rvalid) begin
         cnt_r <= cnt_r + 2'h1;
         if (cnt_r == lat) begin
            mem_rvalid <= 1'b1;
            mem_rdata  <= desc;
            cnt_r      <= 2'h0;
         end
      end
   end
endmodule
